/* pkg/tcc_pkg.sv */
// constants for the timer channel input capture configuration block
package tcc_pkg;
  // register byte offsets
  localparam logic [3:0] ADR_MODE = 4'h0;
  localparam logic [3:0] ADR_ENA  = 4'h4;
  localparam logic [3:0] ADR_CAPT = 4'h8;
  localparam logic [3:0] ADR_STAT = 4'hC;
  // field positions in the mode register
  localparam int FLT_LSB = 4;
  localparam int DIV_LSB = 2;
  localparam int DIR_LSB = 0;
  // field positions in the enable/polarity register
  localparam int ENA_BIT  = 0;
  localparam int POL_BIT  = 1;
  localparam int NPOL_BIT = 3;
  // reset values
  localparam logic [3:0]  FLT_RST  = 4'h0;
  localparam logic [1:0]  DIV_RST  = 2'h0;
  localparam logic [1:0]  DIR_RST  = 2'h0;
  localparam logic        ENA_RST  = 1'h0;
  localparam logic        POL_RST  = 1'h0;
  localparam logic        NPOL_RST = 1'h0;
  localparam logic [15:0] CAPT_RST = 16'h0000;
  // direction codes
  localparam logic [1:0] DIR_OUT = 2'h0;
  localparam logic [1:0] DIR_IN  = 2'h1;
  // filter code table: log2 of sampling divider and samples needed
  localparam logic [2:0] FLT_DIVLOG [16] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h2,
                                            3'h3, 3'h3, 3'h4, 3'h4, 3'h4, 3'h5, 3'h5, 3'h5};
  localparam logic [3:0] FLT_LEN [16] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h8, 4'h6, 4'h8,
                                         4'h6, 4'h8, 4'h5, 4'h6, 4'h8, 4'h5, 4'h6, 4'h8};
  // bus answers one cycle after the request is seen
  localparam int ACK_LAT_CYC = 1;
endpackage

/* src/tcc_top.sv */
// timer channel input filter, capture prescaler, direction and polarity control
`timescale 1ns/1ps
module tcc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        channel_input_signal_i,
  input  wire logic [15:0] counter_value_i,
  input  wire logic        compare_ref_i,
  output logic             channel_output_signal_o,
  output logic             channel_output_enable_o,
  output logic             capture_strobe_o
);

  logic        ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [3:0]  flt_ff, nxt_flt;
  logic [1:0]  div_ff, nxt_div;
  logic [1:0]  dir_ff, nxt_dir;
  logic        ena_ff, nxt_ena;
  logic        pol_ff, nxt_pol;
  logic        npol_ff, nxt_npol;
  logic [4:0]  smp_cnt_ff, nxt_smp_cnt;
  logic [2:0]  flt_cnt_ff, nxt_flt_cnt;
  logic        filt_ff, nxt_filt;
  logic        prev_ff, nxt_prev;
  logic [2:0]  psc_ff, nxt_psc;
  logic [15:0] capt_ff, nxt_capt;
  logic        cstb_ff, nxt_cstb;
  logic        out_ff, nxt_out;
  logic        oe_ff, nxt_oe;
  logic        req;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        edge_evt;
  logic        active;
  logic        capt_evt;
  logic [4:0]  smp_mask;
  logic [2:0]  psc_mask;
  logic [2:0]  flt_last;
  logic [31:0] mode_rd;
  logic [31:0] ena_rd;
  logic [31:0] stat_rd;

  assign req      = cyc_i && stb_i && !ack_ff;
  assign mode_rd  = {24'h000000, flt_ff, div_ff, dir_ff};
  assign ena_rd   = {28'h0000000, npol_ff, 1'b0, pol_ff, ena_ff};
  assign stat_rd  = {28'h0000000, psc_ff, filt_ff};

  // bus slave: register writes, read mux and single-cycle acknowledge
  always_comb begin
    nxt_ack  = req;
    nxt_rdat = rdat_ff;
    nxt_flt  = flt_ff;
    nxt_div  = div_ff;
    nxt_dir  = dir_ff;
    nxt_ena  = ena_ff;
    nxt_pol  = pol_ff;
    nxt_npol = npol_ff;
    if (req && !we_i) begin
      case (adr_i)
        tcc_pkg::ADR_MODE: nxt_rdat = mode_rd;
        tcc_pkg::ADR_ENA:  nxt_rdat = ena_rd;
        tcc_pkg::ADR_CAPT: nxt_rdat = {16'h0000, capt_ff};
        tcc_pkg::ADR_STAT: nxt_rdat = stat_rd;
        default:           nxt_rdat = 32'h00000000; // unmapped reads zero
      endcase
    end
    if (req && we_i && sel_i[0]) begin
      case (adr_i)
        tcc_pkg::ADR_MODE: begin
          nxt_flt = dat_i[tcc_pkg::FLT_LSB +: 4];
          nxt_div = dat_i[tcc_pkg::DIV_LSB +: 2];
          if (!ena_ff) begin
            nxt_dir = dat_i[tcc_pkg::DIR_LSB +: 2];
          end
        end
        tcc_pkg::ADR_ENA: begin
          nxt_ena  = dat_i[tcc_pkg::ENA_BIT];
          nxt_pol  = dat_i[tcc_pkg::POL_BIT];
          nxt_npol = dat_i[tcc_pkg::NPOL_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // bus and configuration registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h00000000;
      flt_ff  <= tcc_pkg::FLT_RST;
      div_ff  <= tcc_pkg::DIV_RST;
      dir_ff  <= tcc_pkg::DIR_RST;
      ena_ff  <= tcc_pkg::ENA_RST;
      pol_ff  <= tcc_pkg::POL_RST;
      npol_ff <= tcc_pkg::NPOL_RST;
    end else begin
      ack_ff  <= nxt_ack;
      rdat_ff <= nxt_rdat;
      flt_ff  <= nxt_flt;
      div_ff  <= nxt_div;
      dir_ff  <= nxt_dir;
      ena_ff  <= nxt_ena;
      pol_ff  <= nxt_pol;
      npol_ff <= nxt_npol;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  // sampling divider and event-counter filter
  assign smp_mask = 5'((6'h01 << tcc_pkg::FLT_DIVLOG[flt_ff]) - 6'h01);
  assign tick     = (smp_cnt_ff & smp_mask) == 5'h00;
  assign flt_last = 3'(tcc_pkg::FLT_LEN[flt_ff] - 4'h1);

  always_comb begin
    nxt_smp_cnt = 5'(smp_cnt_ff + 5'h01);
    nxt_flt_cnt = flt_cnt_ff;
    nxt_filt    = filt_ff;
    if (tick) begin
      if (channel_input_signal_i == filt_ff) begin
        nxt_flt_cnt = 3'h0; // disagreement streak broken
      end else if (flt_cnt_ff >= flt_last) begin // a streak longer than a new code also ends
        nxt_filt    = channel_input_signal_i;
        nxt_flt_cnt = 3'h0;
      end else begin
        nxt_flt_cnt = 3'(flt_cnt_ff + 3'h1);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      smp_cnt_ff <= 5'h00;
      flt_cnt_ff <= 3'h0;
      filt_ff    <= 1'b0;
    end else begin
      smp_cnt_ff <= nxt_smp_cnt;
      flt_cnt_ff <= nxt_flt_cnt;
      filt_ff    <= nxt_filt;
    end
  end

  // polarity-selected edge detect, prescaler, capture latch, output stage
  assign rise     = filt_ff && !prev_ff;
  assign fall     = !filt_ff && prev_ff;
  assign active   = ena_ff && (dir_ff == tcc_pkg::DIR_IN);
  assign psc_mask = 3'((4'h1 << div_ff) - 4'h1);

  always_comb begin
    case ({pol_ff, npol_ff})
      2'h0:    edge_evt = rise;
      2'h2:    edge_evt = fall;
      2'h3:    edge_evt = rise || fall;
      default: edge_evt = 1'b0; // reserved pair never triggers
    endcase
  end

  // a count above a newly lowered divider still closes the group
  assign capt_evt = active && edge_evt && (psc_ff >= psc_mask);

  always_comb begin
    nxt_prev = filt_ff;
    nxt_psc  = psc_ff;
    nxt_capt = capt_ff;
    nxt_cstb = capt_evt;
    if (!ena_ff) begin
      nxt_psc = 3'h0;
    end else if (active && edge_evt) begin
      nxt_psc = capt_evt ? 3'h0 : 3'(psc_ff + 3'h1);
    end
    if (capt_evt) begin
      nxt_capt = counter_value_i;
    end
    // output stage ignores the complement bit
    nxt_oe  = ena_ff && (dir_ff == tcc_pkg::DIR_OUT);
    nxt_out = nxt_oe ? (compare_ref_i ^ pol_ff) : 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_ff <= 1'b0;
      psc_ff  <= 3'h0;
      capt_ff <= tcc_pkg::CAPT_RST;
      cstb_ff <= 1'b0;
      out_ff  <= 1'b0;
      oe_ff   <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
      psc_ff  <= nxt_psc;
      capt_ff <= nxt_capt;
      cstb_ff <= nxt_cstb;
      out_ff  <= nxt_out;
      oe_ff   <= nxt_oe;
    end
  end

  assign capture_strobe_o        = cstb_ff;
  assign channel_output_signal_o = out_ff;
  assign channel_output_enable_o = oe_ff;

  // checks on the channel behaviour
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_ACK_ONE: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus ack not a single cycle pulse");
  AST_PSC_CLEAR: assert property (!ena_ff |=> psc_ff == 3'h0)
    else $error("prescaler count not cleared while disabled");
  AST_DIR_LOCK: assert property (ena_ff |=> $stable(dir_ff))
    else $error("direction changed while channel enabled");
  AST_UNFILT: assert property (flt_ff == 4'h0 |=> filt_ff == $past(channel_input_signal_i))
    else $error("unfiltered path did not follow input");
  AST_FLT_HOLD: assert property (channel_input_signal_i == filt_ff |=> $stable(filt_ff))
    else $error("filter output moved on agreeing sample");
  AST_FLT_N2: assert property ($stable(flt_ff) && flt_ff == 4'h1 && flt_cnt_ff == 3'h0
      && channel_input_signal_i != filt_ff
      ##1 flt_ff == 4'h1 && channel_input_signal_i != filt_ff
      |=> filt_ff == $past(channel_input_signal_i))
    else $error("two-sample filter did not switch");
  AST_FLT_DIV: assert property (flt_ff >= 4'h4 && !tick |=> $stable(filt_ff))
    else $error("filter moved between sample ticks");
  AST_DIV1: assert property (div_ff == 2'h0 && active && edge_evt |-> capt_evt)
    else $error("undivided capture missed an edge");
  AST_RESV_POL: assert property (!pol_ff && npol_ff |-> !edge_evt)
    else $error("reserved polarity pair produced an event");
  AST_GATE: assert property (!active |-> !capt_evt)
    else $error("capture while channel not an enabled input");
  AST_CAPT: assert property (capt_evt |=> capture_strobe_o
      && capt_ff == $past(counter_value_i))
    else $error("capture did not latch counter in one clock");
  AST_OUT_POL: assert property (ena_ff && dir_ff == tcc_pkg::DIR_OUT
      |=> channel_output_enable_o
      && channel_output_signal_o == ($past(compare_ref_i) ^ $past(pol_ff)))
    else $error("output polarity or enable wrong");

  // bus side: no acknowledge without a request, writes land as addressed
  AST_ACK_ONLY: assert property (!req |=> !ack_o)
    else $error("bus ack without a request");
  AST_DIR_WR: assert property (req && we_i && sel_i[0] && !ena_ff
      && adr_i == tcc_pkg::ADR_MODE |=> dir_ff == $past(dat_i[tcc_pkg::DIR_LSB +: 2]))
    else $error("direction write lost while disabled");
  AST_ENA_WR: assert property (req && we_i && sel_i[0]
      && adr_i == tcc_pkg::ADR_ENA |=> ena_ff == $past(dat_i[tcc_pkg::ENA_BIT]))
    else $error("enable write lost");

  // prescaler: steps once per accepted edge, restarts after each capture
  AST_PSC_WRAP: assert property (capt_evt |=> psc_ff == 3'h0)
    else $error("prescaler not restarted after capture");
  AST_PSC_STEP: assert property (active && edge_evt && !capt_evt
      |=> psc_ff == 3'($past(psc_ff) + 3'h1))
    else $error("prescaler did not count an edge");
  AST_PSC_IDLE: assert property (ena_ff && !(active && edge_evt) |=> $stable(psc_ff))
    else $error("prescaler moved without an edge");

  // edge sense checked against the filtered level one clock back
  AST_SENSE_RISE: assert property (!pol_ff && !npol_ff
      |-> edge_evt == (filt_ff && !$past(filt_ff)))
    else $error("rising sense wrong");
  AST_SENSE_FALL: assert property (pol_ff && !npol_ff
      |-> edge_evt == (!filt_ff && $past(filt_ff)))
    else $error("falling sense wrong");
  AST_SENSE_BOTH: assert property (pol_ff && npol_ff
      |-> edge_evt == (filt_ff != $past(filt_ff)))
    else $error("either-edge sense wrong");

  // capture register and strobe move only on a capture event
  AST_STRB_SRC: assert property (capture_strobe_o |-> $past(capt_evt))
    else $error("strobe without a capture event");
  AST_CAPT_HOLD: assert property (!capt_evt |=> $stable(capt_ff))
    else $error("capture register moved without an event");

  // the pin is released and low unless the channel is an enabled output
  AST_NO_DRIVE: assert property (!ena_ff || dir_ff != tcc_pkg::DIR_OUT
      |=> !channel_output_enable_o && !channel_output_signal_o)
    else $error("channel drives while not an enabled output");

  // eight-sample filter holds until the eighth disagreeing sample
  AST_FLT_N8: assert property (flt_ff == 4'h3 && flt_cnt_ff != 3'h7 |=> $stable(filt_ff))
    else $error("eight-sample filter switched early");

  COV_CAPT_DIV8: cover property (div_ff == 2'h3 && capt_evt);
  COV_FLT_MAX: cover property (flt_ff == 4'hF && $changed(filt_ff));
  COV_DIR_BLOCK: cover property (req && we_i && adr_i == tcc_pkg::ADR_MODE && ena_ff);
  COV_BOTH_EDGES: cover property (pol_ff && npol_ff && fall && capt_evt);

endmodule

/* test/tcc_pin_model.sv */
// far-side model of the timer input pin: one high pulse per request
`timescale 1ns/1ps
module tcc_pin_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic [7:0] len_i,
  output logic            pin_o
);
  logic [7:0] left_ff;

  // pin stays high for len_i cycles after go_i, then returns low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_ff <= 8'h00;
      pin_o   <= 1'b0;
    end else if (go_i) begin
      left_ff <= len_i - 8'h01;
      pin_o   <= 1'b1;
    end else if (left_ff != 8'h00) begin
      left_ff <= left_ff - 8'h01;
    end else begin
      pin_o <= 1'b0;
    end
  end
endmodule

/* test/tb_top.sv */
// self-checking bench for the timer channel capture configuration block
`timescale 1ns/1ps
module tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, go, cref, ack, pin, out, oe, strb;
  logic [3:0]  adr, sel;
  logic [31:0] dat, rdat, q;
  logic [7:0]  len;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] last_exp;
  int          bad_count, checked, caps, cycles, c0, i, j;
  // mode, enable and expected capture count of each capture case
  localparam logic [7:0] MODES [10] = '{8'h01, 8'h05, 8'h09, 8'h0D, 8'h0D,
                                        8'h01, 8'h01, 8'h01, 8'h02, 8'h01};
  localparam logic [7:0] ENAS [10] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01,
                                       8'h03, 8'h0B, 8'h09, 8'h01, 8'h00};
  localparam int EXPS [10] = '{8, 4, 2, 1, 0, 8, 16, 0, 0, 0};
  // filter codes with their sampling divider and sample count
  localparam logic [3:0] FCODE [5] = '{4'h1, 4'h3, 4'h5, 4'hA, 4'hD};
  localparam int FDIV [5] = '{1, 1, 2, 16, 32};
  localparam int FLEN [5] = '{2, 8, 8, 5, 5};

  always #2 clk_i = ~clk_i;

  tcc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .channel_input_signal_i(pin),
    .counter_value_i(cnt), .compare_ref_i(cref), .channel_output_signal_o(out),
    .channel_output_enable_o(oe), .capture_strobe_o(strb));

  tcc_pin_model pin_mdl (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .len_i(len), .pin_o(pin));

  // free counter, capture tally and run limit
  always @(posedge clk_i) begin
    cnt <= cnt + 16'h0001;
    cycles <= cycles + 1;
    if (strb === 1'b1) begin
      caps <= caps + 1;
      last_exp <= cnt - 16'h0001;
    end
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  // one classic bus cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic pulse(input int l, input int g);
    @(posedge clk_i);
    go <= 1'b1;
    len <= 8'(l);
    @(posedge clk_i);
    go <= 1'b0;
    repeat (l + g) @(posedge clk_i);
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    {cyc, stb, we, go, cref, adr, sel, dat, len} = '0;
    sel = 4'hF;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(tcc_pkg::ADR_MODE, 32'h0);
    rd(tcc_pkg::ADR_ENA, 32'h0);
    rd(tcc_pkg::ADR_CAPT, 32'h0);
    rd(tcc_pkg::ADR_STAT, 32'h0);
    rd(4'h2, 32'h0);
    $display("test reset done");
    wb(1'b1, tcc_pkg::ADR_MODE, 32'h01);
    wb(1'b1, tcc_pkg::ADR_ENA, 32'h0B);
    rd(tcc_pkg::ADR_ENA, 32'h0B);
    wb(1'b1, tcc_pkg::ADR_MODE, 32'h30);
    rd(tcc_pkg::ADR_MODE, 32'h31);
    chk(32'(oe), 32'h0);
    wb(1'b1, tcc_pkg::ADR_ENA, 32'h0);
    wb(1'b1, tcc_pkg::ADR_MODE, 32'h0);
    rd(tcc_pkg::ADR_MODE, 32'h0);
    $display("test direction done");
    cref <= 1'b1;
    for (i = 0; i < 4; i++) begin
      wb(1'b1, tcc_pkg::ADR_ENA, {28'h0, i[1], 1'b0, i[0], 1'b1});
      repeat (2) @(posedge clk_i);
      chk(32'(oe), 32'h1);
      chk(32'(out), {31'h0, ~i[0]});
    end
    cref <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk(32'(out), 32'h1);
    wb(1'b1, tcc_pkg::ADR_ENA, 32'h2);
    repeat (2) @(posedge clk_i);
    chk(32'({oe, out}), 32'h0);
    $display("test output done");
    for (i = 0; i < 10; i++) begin
      wb(1'b1, tcc_pkg::ADR_ENA, 32'h0);
      wb(1'b1, tcc_pkg::ADR_MODE, {24'h0, MODES[i]});
      wb(1'b1, tcc_pkg::ADR_ENA, {24'h0, ENAS[i]});
      c0 = caps;
      for (j = 0; j < 8; j++) begin
        if (i == 4 && j == 4) begin
          wb(1'b1, tcc_pkg::ADR_ENA, 32'h0);
          wb(1'b1, tcc_pkg::ADR_ENA, 32'h1);
        end
        pulse(4, 8);
      end
      chk(32'(caps - c0), 32'(EXPS[i]));
      if (EXPS[i] != 0) rd(tcc_pkg::ADR_CAPT, {16'h0, last_exp});
      if (i == 4) rd(tcc_pkg::ADR_STAT, 32'h8);
    end
    $display("test capture done");
    for (i = 0; i < 5; i++) begin
      wb(1'b1, tcc_pkg::ADR_ENA, 32'h0);
      wb(1'b1, tcc_pkg::ADR_MODE, {24'h0, FCODE[i], 4'h1});
      wb(1'b1, tcc_pkg::ADR_ENA, 32'h1);
      c0 = caps;
      pulse(FDIV[i] * (FLEN[i] - 1), FDIV[i] * (FLEN[i] + 3) + 8);
      chk(32'(caps - c0), 32'h0);
      pulse(FDIV[i] * (FLEN[i] + 2), FDIV[i] * (FLEN[i] + 3) + 8);
      chk(32'(caps - c0), 32'h1);
    end
    $display("test filter done");
    end_sim();
  end
endmodule
